/* rtl/asc_pkg.sv */
// constants shared by the converter sequencing control block
package asc_pkg;
    localparam int unsigned ASC_ADDR_W = 8;
    localparam int unsigned ASC_DATA_W = 32;
    localparam int unsigned ASC_RES_W = 10;
    localparam int unsigned ASC_NCH = 4;
    localparam int unsigned ASC_DIV_W = 7;

    // register byte addresses
    localparam logic [7:0] ASC_CTRL0_ADDR = 8'h00;
    localparam logic [7:0] ASC_CTRL1_ADDR = 8'h04;
    localparam logic [7:0] ASC_RES_HI_ADDR = 8'h08;
    localparam logic [7:0] ASC_RES_LO_ADDR = 8'h0c;
    localparam logic [7:0] ASC_PINSEL_ADDR = 8'h10;
    localparam logic [7:0] ASC_INTCTL_ADDR = 8'h14;

    // control word 0 fields
    localparam int unsigned ASC_START_BIT = 7;
    localparam int unsigned ASC_BUSY_BIT = 6;
    localparam int unsigned ASC_PWR_BIT = 5;
    localparam int unsigned ASC_JUST_BIT = 4;
    localparam int unsigned ASC_CHAN_LSB = 0;
    localparam int unsigned ASC_CHAN_W = 4;

    // control word 1 fields
    localparam int unsigned ASC_INS_LSB = 5;
    localparam int unsigned ASC_INS_W = 3;
    localparam int unsigned ASC_REF_LSB = 3;
    localparam int unsigned ASC_REF_W = 2;
    localparam int unsigned ASC_CKD_LSB = 0;
    localparam int unsigned ASC_CKD_W = 3;

    // pin select fields: one bit per analog input, one for the reference pin
    localparam int unsigned ASC_PSEL_CH_LSB = 0;
    localparam int unsigned ASC_PSEL_VREF_BIT = 4;

    // interrupt control fields
    localparam int unsigned ASC_IRQ_FLAG_BIT = 0;
    localparam int unsigned ASC_IRQ_EN_BIT = 1;
    localparam int unsigned ASC_IRQ_MEN_BIT = 2;

    // reference select codes
    localparam logic [1:0] ASC_REF_SUPPLY = 2'h1;
    localparam logic [1:0] ASC_REF_OPAMP = 2'h2;

    // input source codes
    localparam logic [2:0] ASC_INS_DIV4 = 3'h4;
    localparam logic [2:0] ASC_INS_GND_LO = 3'h1;
    localparam logic [2:0] ASC_INS_GND_HI = 3'h3;

    // highest channel code that reaches a pin
    localparam logic [3:0] ASC_CHAN_LAST = 4'h3;

    // conversion length in conversion clock periods
    localparam logic [3:0] ASC_SAMPLE_TICKS = 4'h4;
    localparam logic [3:0] ASC_CONV_TICKS = 4'ha;

    localparam logic [9:0] ASC_SAR_MSB = 10'h200;
    localparam logic [31:0] ASC_RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        ASC_IDLE,
        ASC_SAMPLE,
        ASC_CONVERT
    } asc_state_t;
endpackage

/* rtl/asc_clkdiv.sv */
// conversion clock tick generator: system clock divided by a power of two
module asc_clkdiv
    import asc_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic restart,
    input wire logic [ASC_CKD_W-1:0] div_code,
    output logic tick
);
    logic [ASC_DIV_W-1:0] count_reg;
    logic [ASC_DIV_W-1:0] count_next;
    logic tick_next;
    wire logic [ASC_DIV_W-1:0] limit;

    // divide by 2^code: terminal count is 2^code - 1
    function automatic logic [ASC_DIV_W-1:0] div_limit(input logic [ASC_CKD_W-1:0] code);
        logic [ASC_DIV_W:0] one_hot;
        one_hot = '0;
        one_hot[code] = 1'b1;
        div_limit = ASC_DIV_W'(one_hot - 1'b1);
    endfunction

    assign limit = div_limit(div_code);

    always_comb
    begin
        count_next = count_reg + 1'b1;
        tick_next = 1'b0;
        if (restart)
        begin
            count_next = '0;
        end
        else if (count_reg >= limit)
        begin
            // >= keeps a shrinking divider from wrapping through 127
            count_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            count_reg <= '0;
            tick <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick <= tick_next;
        end
    end
endmodule

/* rtl/asc_top.sv */
// converter sequencing control: APB registers, routing, start, SAR timing
//
// Behaviour
// - reference: 01 supply, 10 opamp, else pin
// - source: 000/101-111 external, 100 div4, else ground
// - channel codes 0-3 connect pins, others float
// - analog pin drops all other functions
// - analog pin loses its pull-up
// - analog selection overrides port direction
// - start low-high-low begins one conversion
// - busy set once conversion initiated
// - completion clears busy, sets request flag
// - enabled request raises interrupt, else poll
// - conversion clock divides by 1 to 128
// - converter powered only while enable high
// - 14 periods: 4 sample, 10 convert
// - 10-bit result left or right justified
// - result held while converter disabled
//
// The register offsets and the APB register port are this design's own decisions.
module asc_top
    import asc_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ASC_ADDR_W-1:0] PADDR,
    input wire logic [ASC_DATA_W-1:0] PWDATA,
    output logic [ASC_DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic COMP_IN,
    output logic ADC_POWER,
    output logic REF_SUPPLY,
    output logic REF_OPAMP,
    output logic REF_PIN,
    output logic REF_PIN_ANALOG,
    output logic [ASC_NCH-1:0] AIN_CH_EN,
    output logic AIN_SUPPLY_DIV4,
    output logic AIN_GROUND,
    output logic [ASC_NCH-1:0] PIN_ANALOG_MODE,
    output logic [ASC_NCH-1:0] PIN_PULLUP_OFF,
    output logic [ASC_NCH-1:0] PIN_DIR_FORCE_IN,
    output logic SAMPLE_EN,
    output logic [ASC_RES_W-1:0] DAC_CODE,
    output logic IRQ
);
    // software state
    logic start_reg;
    logic start_armed_reg;
    logic pwr_reg;
    logic just_reg;
    logic [ASC_CHAN_W-1:0] chan_reg;
    logic [ASC_INS_W-1:0] ins_reg;
    logic [ASC_REF_W-1:0] ref_reg;
    logic [ASC_CKD_W-1:0] ckd_reg;
    logic [ASC_NCH-1:0] pin_an_reg;
    logic vref_an_reg;
    logic irq_flag_reg;
    logic irq_en_reg;
    logic irq_men_reg;

    // sequencer state
    asc_state_t state_reg;
    asc_state_t state_next;
    logic busy_reg;
    logic [3:0] phase_cnt_reg;
    logic [3:0] phase_cnt_next;
    logic [ASC_RES_W-1:0] sar_reg;
    logic [ASC_RES_W-1:0] sar_next;
    logic [ASC_RES_W-1:0] bit_reg;
    logic [ASC_RES_W-1:0] bit_next;
    logic [ASC_RES_W-1:0] result_reg;
    logic comp_meta_reg;
    logic comp_sync_reg;

    // bus answer
    logic pready_reg;

    wire logic setup_done;
    wire logic wr_done;
    wire logic hit_ctrl0;
    wire logic hit_ctrl1;
    wire logic hit_res_hi;
    wire logic hit_res_lo;
    wire logic hit_pinsel;
    wire logic hit_intctl;
    wire logic addr_ok;
    wire logic [ASC_DATA_W-1:0] rd_word;
    wire logic [15:0] res_pair;
    wire logic start_wr_val;
    wire logic start_fall;
    wire logic conv_tick;
    wire logic div_restart;
    wire logic conv_done;
    wire logic abort;
    wire logic ins_external;
    wire logic ins_ground;
    wire logic [ASC_NCH-1:0] chan_onehot;

    // byte pair as firmware sees it
    function automatic logic [15:0] fmt_result(input logic [ASC_RES_W-1:0] res,
                                               input logic right);
        fmt_result = right ? {6'h00, res} : {res, 6'h00};
    endfunction

    function automatic logic [ASC_NCH-1:0] chan_decode(input logic [ASC_CHAN_W-1:0] code);
        chan_decode = '0;
        if (code <= ASC_CHAN_LAST)
        begin
            chan_decode[code[1:0]] = 1'b1;
        end
    endfunction

    // apb: one wait state so read data leaves a flop
    assign setup_done = PSEL && PENABLE && !pready_reg;
    assign wr_done = PSEL && PENABLE && pready_reg && PWRITE;
    assign PREADY = pready_reg;
    assign hit_ctrl0 = (PADDR == ASC_CTRL0_ADDR);
    assign hit_ctrl1 = (PADDR == ASC_CTRL1_ADDR);
    assign hit_res_hi = (PADDR == ASC_RES_HI_ADDR);
    assign hit_res_lo = (PADDR == ASC_RES_LO_ADDR);
    assign hit_pinsel = (PADDR == ASC_PINSEL_ADDR);
    assign hit_intctl = (PADDR == ASC_INTCTL_ADDR);
    assign addr_ok = hit_ctrl0 || hit_ctrl1 || hit_res_hi || hit_res_lo
        || hit_pinsel || hit_intctl;

    assign res_pair = fmt_result(result_reg, just_reg);
    assign rd_word =
        hit_ctrl0 ? {24'h000000, start_reg, busy_reg, pwr_reg, just_reg, chan_reg} :
        hit_ctrl1 ? {24'h000000, ins_reg, ref_reg, ckd_reg} :
        hit_res_hi ? {24'h000000, res_pair[15:8]} :
        hit_res_lo ? {24'h000000, res_pair[7:0]} :
        hit_pinsel ? {27'h0000000, vref_an_reg, pin_an_reg} :
        hit_intctl ? {29'h00000000, irq_men_reg, irq_en_reg, irq_flag_reg} :
        ASC_RST_WORD;

    // start handshake: rise arms, following fall fires
    assign start_wr_val = PWDATA[ASC_START_BIT];
    assign start_fall = wr_done && hit_ctrl0 && start_armed_reg && !start_wr_val;

    // a start while the converter is off is dropped
    assign abort = !pwr_reg;
    assign div_restart = start_fall || state_reg == ASC_IDLE;

    assign conv_done = state_reg == ASC_CONVERT && conv_tick
        && phase_cnt_reg == ASC_CONV_TICKS - 4'h1 && !abort;

    // input routing decode
    assign ins_ground = ins_reg >= ASC_INS_GND_LO && ins_reg <= ASC_INS_GND_HI;
    assign ins_external = !ins_ground && ins_reg != ASC_INS_DIV4;
    assign chan_onehot = chan_decode(chan_reg);

    asc_clkdiv u_clkdiv (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .restart(div_restart),
        .div_code(ckd_reg),
        .tick(conv_tick)
    );

    // register writes
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            start_reg <= 1'b0;
            start_armed_reg <= 1'b0;
            pwr_reg <= 1'b0;
            just_reg <= 1'b0;
            chan_reg <= '0;
            ins_reg <= '0;
            ref_reg <= '0;
            ckd_reg <= '0;
            pin_an_reg <= '0;
            vref_an_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            irq_men_reg <= 1'b0;
        end
        else if (wr_done)
        begin
            if (hit_ctrl0)
            begin
                start_reg <= start_wr_val;
                // rising edge of start arms; any later low fires and disarms
                start_armed_reg <= start_wr_val && (start_armed_reg || !start_reg);
                pwr_reg <= PWDATA[ASC_PWR_BIT];
                just_reg <= PWDATA[ASC_JUST_BIT];
                chan_reg <= PWDATA[ASC_CHAN_LSB +: ASC_CHAN_W];
            end
            if (hit_ctrl1)
            begin
                ins_reg <= PWDATA[ASC_INS_LSB +: ASC_INS_W];
                ref_reg <= PWDATA[ASC_REF_LSB +: ASC_REF_W];
                ckd_reg <= PWDATA[ASC_CKD_LSB +: ASC_CKD_W];
            end
            if (hit_pinsel)
            begin
                pin_an_reg <= PWDATA[ASC_PSEL_CH_LSB +: ASC_NCH];
                vref_an_reg <= PWDATA[ASC_PSEL_VREF_BIT];
            end
            if (hit_intctl)
            begin
                irq_en_reg <= PWDATA[ASC_IRQ_EN_BIT];
                irq_men_reg <= PWDATA[ASC_IRQ_MEN_BIT];
            end
        end
    end

    // request flag: completion wins over a same-cycle write-one clear
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            irq_flag_reg <= 1'b0;
        end
        else if (conv_done)
        begin
            irq_flag_reg <= 1'b1;
        end
        else if (wr_done && hit_intctl && PWDATA[ASC_IRQ_FLAG_BIT])
        begin
            irq_flag_reg <= 1'b0;
        end
    end

    // bus answer flops
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            pready_reg <= 1'b0;
            PRDATA <= ASC_RST_WORD;
            PSLVERR <= 1'b0;
        end
        else
        begin
            pready_reg <= setup_done;
            if (setup_done)
            begin
                PRDATA <= PWRITE ? ASC_RST_WORD : rd_word;
                PSLVERR <= !addr_ok;
            end
        end
    end

    // comparator crosses from the analog core
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end
        else
        begin
            comp_meta_reg <= COMP_IN;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // sequencer: sample then successive approximation, msb first
    always_comb
    begin
        state_next = state_reg;
        phase_cnt_next = phase_cnt_reg;
        sar_next = sar_reg;
        bit_next = bit_reg;
        case (state_reg)
            ASC_IDLE:
            begin
                if (start_fall && pwr_reg)
                begin
                    state_next = ASC_SAMPLE;
                    phase_cnt_next = '0;
                end
            end
            ASC_SAMPLE:
            begin
                if (conv_tick)
                begin
                    phase_cnt_next = phase_cnt_reg + 4'h1;
                    if (phase_cnt_reg == ASC_SAMPLE_TICKS - 4'h1)
                    begin
                        state_next = ASC_CONVERT;
                        phase_cnt_next = '0;
                        sar_next = ASC_SAR_MSB;
                        bit_next = ASC_SAR_MSB;
                    end
                end
            end
            ASC_CONVERT:
            begin
                if (conv_tick)
                begin
                    // comparator low: trial code was above the input
                    if (!comp_sync_reg)
                    begin
                        sar_next = sar_reg & ~bit_reg;
                    end
                    else
                    begin
                        sar_next = sar_reg;
                    end
                    sar_next = sar_next | (bit_reg >> 1);
                    bit_next = bit_reg >> 1;
                    phase_cnt_next = phase_cnt_reg + 4'h1;
                    if (phase_cnt_reg == ASC_CONV_TICKS - 4'h1)
                    begin
                        state_next = ASC_IDLE;
                    end
                end
            end
            default:
            begin
                state_next = ASC_IDLE;
            end
        endcase
        // a fresh start sequence mid-conversion restarts sampling
        if (start_fall && pwr_reg && state_reg != ASC_IDLE)
        begin
            state_next = ASC_SAMPLE;
            phase_cnt_next = '0;
        end
        if (abort)
        begin
            state_next = ASC_IDLE;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= ASC_IDLE;
            phase_cnt_reg <= '0;
            sar_reg <= '0;
            bit_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            phase_cnt_reg <= phase_cnt_next;
            sar_reg <= sar_next;
            bit_reg <= bit_next;
            busy_reg <= state_next != ASC_IDLE;
        end
    end

    // result only moves on a completed conversion
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            result_reg <= '0;
        end
        else if (conv_done)
        begin
            result_reg <= sar_next;
        end
    end

    // outputs toward analog core, pads and interrupt controller
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ADC_POWER <= 1'b0;
            REF_SUPPLY <= 1'b0;
            REF_OPAMP <= 1'b0;
            REF_PIN <= 1'b0;
            REF_PIN_ANALOG <= 1'b0;
            AIN_CH_EN <= '0;
            AIN_SUPPLY_DIV4 <= 1'b0;
            AIN_GROUND <= 1'b0;
            PIN_ANALOG_MODE <= '0;
            PIN_PULLUP_OFF <= '0;
            PIN_DIR_FORCE_IN <= '0;
            SAMPLE_EN <= 1'b0;
            DAC_CODE <= '0;
            IRQ <= 1'b0;
        end
        else
        begin
            ADC_POWER <= pwr_reg;
            REF_SUPPLY <= ref_reg == ASC_REF_SUPPLY;
            REF_OPAMP <= ref_reg == ASC_REF_OPAMP;
            REF_PIN <= ref_reg != ASC_REF_SUPPLY && ref_reg != ASC_REF_OPAMP;
            // pad kept off the internal reference even if firmware errs
            REF_PIN_ANALOG <= vref_an_reg && ref_reg != ASC_REF_SUPPLY
                && ref_reg != ASC_REF_OPAMP;
            AIN_CH_EN <= ins_external ? chan_onehot : '0;
            AIN_SUPPLY_DIV4 <= ins_reg == ASC_INS_DIV4;
            AIN_GROUND <= ins_ground;
            PIN_ANALOG_MODE <= pin_an_reg;
            PIN_PULLUP_OFF <= pin_an_reg;
            PIN_DIR_FORCE_IN <= pin_an_reg;
            SAMPLE_EN <= state_next == ASC_SAMPLE;
            DAC_CODE <= sar_next;
            IRQ <= (irq_flag_reg || conv_done) && irq_en_reg && irq_men_reg;
        end
    end
endmodule

/* dv/asc_assertions.sv */
// port-level assertions for the converter sequencing control block
module asc_assertions
    import asc_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic ADC_POWER,
    input wire logic REF_SUPPLY,
    input wire logic REF_OPAMP,
    input wire logic REF_PIN,
    input wire logic REF_PIN_ANALOG,
    input wire logic [ASC_NCH-1:0] AIN_CH_EN,
    input wire logic AIN_SUPPLY_DIV4,
    input wire logic AIN_GROUND,
    input wire logic [ASC_NCH-1:0] PIN_ANALOG_MODE,
    input wire logic [ASC_NCH-1:0] PIN_PULLUP_OFF,
    input wire logic [ASC_NCH-1:0] PIN_DIR_FORCE_IN,
    input wire logic SAMPLE_EN,
    input wire logic [ASC_RES_W-1:0] DAC_CODE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_one_ready;
        PREADY ##1 !PREADY;
    endsequence
    // an abort may cut sampling short, so power loss also ends the window
    sequence s_sampling;
        (SAMPLE_EN || !ADC_POWER) [*4];
    endsequence
    chk_apb_one_wait:
        assert property (s_access |=> s_one_ready)
        else $error("ready did not follow one wait state");
    chk_err_with_ready:
        assert property ($rose(PSLVERR) |-> PREADY)
        else $error("error rose without ready");
    chk_ref_onehot:
        assert property ($onehot0({REF_SUPPLY, REF_OPAMP, REF_PIN}))
        else $error("more than one reference routed");
    chk_ref_pin_gate:
        assert property (REF_PIN_ANALOG |-> REF_PIN)
        else $error("reference pin analog while internal reference chosen");
    chk_ain_exclusive:
        assert property ($onehot0({AIN_SUPPLY_DIV4, AIN_GROUND, |AIN_CH_EN}) && $onehot0(AIN_CH_EN))
        else $error("input sources overlap");
    chk_pin_modes:
        assert property (PIN_PULLUP_OFF == PIN_ANALOG_MODE && PIN_DIR_FORCE_IN == PIN_ANALOG_MODE)
        else $error("analog pin controls disagree");
    chk_power_sample:
        assert property (!ADC_POWER |-> !SAMPLE_EN)
        else $error("sampling while converter unpowered");
    chk_sample_length:
        assert property ($rose(SAMPLE_EN) |-> s_sampling)
        else $error("sampling shorter than four periods");
    chk_sar_start:
        assert property ($fell(SAMPLE_EN) && ADC_POWER |-> DAC_CODE == ASC_SAR_MSB)
        else $error("first trial code wrong after sampling");
endmodule

bind asc_top asc_assertions u_asc_chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .ADC_POWER(ADC_POWER),
    .REF_SUPPLY(REF_SUPPLY), .REF_OPAMP(REF_OPAMP), .REF_PIN(REF_PIN),
    .REF_PIN_ANALOG(REF_PIN_ANALOG), .AIN_CH_EN(AIN_CH_EN), .AIN_SUPPLY_DIV4(AIN_SUPPLY_DIV4),
    .AIN_GROUND(AIN_GROUND), .PIN_ANALOG_MODE(PIN_ANALOG_MODE), .PIN_PULLUP_OFF(PIN_PULLUP_OFF),
    .PIN_DIR_FORCE_IN(PIN_DIR_FORCE_IN), .SAMPLE_EN(SAMPLE_EN), .DAC_CODE(DAC_CODE));

/* dv/asc_analog_model.sv */
// behavioural analog core: comparator of a target level against the trial code
module asc_analog_model
    import asc_pkg::*;
(
    input wire logic clk,
    input wire logic power,
    input wire logic [ASC_RES_W-1:0] dac_code,
    input wire logic [ASC_RES_W-1:0] target,
    output logic comp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_reg = 1'b0;
    // unpowered core has no valid level, so the output wanders each cycle
    always @(posedge clk) junk_reg <= ~junk_reg;
    assign comp_out = power ? (target >= dac_code) : junk_reg;
endmodule

/* dv/testbench.sv */
// self-checking bench for the converter sequencing control block
module testbench
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, comp_in, adc_power, r_sup, r_opa, r_pin, r_pina, ain_div4, ain_gnd;
    logic sample_en, irq;
    logic [3:0] ain_ch, pin_am, pin_pu, pin_dir;
    logic [9:0] dac_code, target = 10'h0;
    int miscompares = 0, n_compared = 0;
    always #20 clk = ~clk;
    asc_top dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .COMP_IN(comp_in), .ADC_POWER(adc_power), .REF_SUPPLY(r_sup), .REF_OPAMP(r_opa),
        .REF_PIN(r_pin), .REF_PIN_ANALOG(r_pina), .AIN_CH_EN(ain_ch), .AIN_SUPPLY_DIV4(ain_div4),
        .AIN_GROUND(ain_gnd), .PIN_ANALOG_MODE(pin_am), .PIN_PULLUP_OFF(pin_pu),
        .PIN_DIR_FORCE_IN(pin_dir), .SAMPLE_EN(sample_en), .DAC_CODE(dac_code), .IRQ(irq));
    asc_analog_model u_ana (.clk(clk), .power(adc_power), .dac_code(dac_code), .target(target),
        .comp_out(comp_in));
    function automatic logic [5:0] exp_ain(input logic [2:0] s, input logic [3:0] c);
        logic ext;
        ext = (s == 3'h0) || (s > 3'h4);
        exp_ain = {s == 3'h4, s != 3'h0 && s < 3'h4, (ext && c < 4'h4) ? 4'h1 << c : 4'h0};
    endfunction
    function automatic logic [2:0] exp_ref(input logic [1:0] r);
        exp_ref = {r == 2'h1, r == 2'h2, r == 2'h0 || r == 2'h3};
    endfunction
    function automatic logic [15:0] exp_res(input logic [9:0] d, input logic j);
        exp_res = j ? {6'h00, d} : {d, 6'h00};
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one idle cycle before each setup keeps every driver assignment unique per step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            chk("pready", 1, 0);
    endtask
    task automatic convert(input logic [2:0] ckd, input logic j, output int tot, output int smp);
        apb(1'b1, ASC_CTRL1_ADDR, {29'h0, ckd});
        apb(1'b1, ASC_CTRL0_ADDR, {24'h0, 3'h5, j, 4'h0});
        apb(1'b1, ASC_CTRL0_ADDR, {24'h0, 3'h1, j, 4'h0});
        tot = 0;
        smp = 0;
        while (irq !== 1'b1 && tot < 4000)
        begin
            @(posedge clk);
            tot++;
            if (sample_en === 1'b1)
                smp++;
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #2400000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        int tot, smp;
        logic [15:0] r;
        void'($urandom(13));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset_word", ASC_RST_WORD, q);
        end
        apb(1'b1, 8'h18, 32'hff);
        chk("unmapped_err", 1, e);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped_data", 0, q);
        apb(1'b1, ASC_PINSEL_ADDR, 32'h10);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, ASC_CTRL1_ADDR, 32'(i) << ASC_REF_LSB);
            repeat (2) @(posedge clk);
            chk("ref_route", exp_ref(2'(i)), {r_sup, r_opa, r_pin});
            chk("ref_pin_analog", exp_ref(2'(i)) & 3'h1, r_pina);
        end
        for (int s = 0; s < 8; s++)
            for (int c = 0; c < 16; c++)
            begin
                if (s == 4 && c < 4)
                    continue;
                if (s != 4)
                    apb(1'b1, ASC_CTRL1_ADDR, 32'(s) << ASC_INS_LSB);
                apb(1'b1, ASC_CTRL0_ADDR, 32'(c));
                if (s == 4)
                    apb(1'b1, ASC_CTRL1_ADDR, 32'(s) << ASC_INS_LSB);
                repeat (2) @(posedge clk);
                chk("input_route", exp_ain(3'(s), 4'(c)), {ain_div4, ain_gnd, ain_ch});
            end
        repeat (8)
        begin
            r = 16'($urandom());
            apb(1'b1, ASC_PINSEL_ADDR, {28'h0, r[3:0]});
            repeat (2) @(posedge clk);
            chk("pin_modes", {3{r[3:0]}}, {pin_am, pin_pu, pin_dir});
        end
        apb(1'b1, ASC_CTRL0_ADDR, 32'h80);
        apb(1'b1, ASC_CTRL0_ADDR, 32'h00);
        apb(1'b0, ASC_CTRL0_ADDR, 32'h0);
        chk("fire_unpowered", 0, q[ASC_BUSY_BIT]);
        apb(1'b1, ASC_INTCTL_ADDR, 32'h6);
        apb(1'b1, ASC_CTRL0_ADDR, 32'h20);
        repeat (20) @(posedge clk);
        chk("adc_power_on", 1, adc_power);
        for (int k = 0; k < 8; k++)
        begin
            // fast dividers leave the period range: only rail levels are exact there
            target = (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : 10'($urandom());
            convert(3'(k), k[0], tot, smp);
            chk("conv_cycles", 1, tot >= (14 << k) - 1 && tot <= (14 << k) + 2);
            chk("sample_cycles", 1, smp >= (4 << k) - 1 && smp <= (4 << k) + 1);
            apb(1'b0, ASC_CTRL0_ADDR, 32'h0);
            chk("busy_done", 0, q[ASC_BUSY_BIT]);
            apb(1'b0, ASC_INTCTL_ADDR, 32'h0);
            chk("req_flag", 32'h7, q);
            apb(1'b1, ASC_INTCTL_ADDR, k[1] ? 32'h2 : 32'h4);
            repeat (2) @(posedge clk);
            chk("irq_masked", 0, irq);
            apb(1'b1, ASC_INTCTL_ADDR, 32'h7);
            repeat (2) @(posedge clk);
            chk("irq_cleared", 0, irq);
            r = exp_res(target, k[0]);
            apb(1'b0, ASC_RES_HI_ADDR, 32'h0);
            chk("result_hi", r[15:8], q);
            apb(1'b0, ASC_RES_LO_ADDR, 32'h0);
            chk("result_lo", r[7:0], q);
        end
        // abort inside the sampling phase of a slow conversion, justify kept at right
        target = 10'h155;
        apb(1'b1, ASC_CTRL0_ADDR, 32'hb0);
        apb(1'b1, ASC_CTRL0_ADDR, 32'h30);
        apb(1'b0, ASC_CTRL0_ADDR, 32'h0);
        chk("busy_set", 1, q[ASC_BUSY_BIT]);
        repeat (300) @(posedge clk);
        apb(1'b1, ASC_CTRL0_ADDR, 32'h10);
        repeat (2000) @(posedge clk);
        apb(1'b0, ASC_CTRL0_ADDR, 32'h0);
        chk("busy_abort", 0, q[ASC_BUSY_BIT]);
        chk("adc_power_off", 0, adc_power);
        apb(1'b0, ASC_INTCTL_ADDR, 32'h0);
        chk("flag_abort", 32'h6, q);
        chk("irq_quiet", 0, irq);
        apb(1'b0, ASC_RES_LO_ADDR, 32'h0);
        chk("result_kept", r[7:0], q);
        print_verdict();
    end
endmodule
